// file: core/sbsc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbsc_defs.svh"
module sbsc_top #(
  parameter int AW = `SBSC_ADDR_W,
  parameter int LANES = `SBSC_LANES,
  parameter int LW = `SBSC_LANE_W,
  parameter bit HAS_PARITY = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // address and control pins
  input wire logic [AW-1:0] addr_i,
  input wire sbsc_pkg::sbsc_sel_t sel_i,
  input wire sbsc_pkg::sbsc_strb_t strb_i,
  input wire sbsc_pkg::sbsc_wr_t wr_i,
  input wire logic burst_order_i,
  input wire logic output_enable_n_i,
  input wire logic snooze_request_i,
  // data pins, split three ways
  input wire logic [LANES*LW-1:0] data_i,
  output logic [LANES*LW-1:0] data_o,
  output logic [LANES*LW-1:0] data_oe_n_o,
  // status
  output logic snoozing_o,
  output logic powered_down_o
);
  import sbsc_pkg::*;

  // ==========================================================
  // pin synchronisers for asynchronous inputs
  logic [1:0] oe_sync_q;
  logic [1:0] zz_sync_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_sync_q <= 2'h3;
      zz_sync_q <= 2'h0;
    end else begin
      oe_sync_q <= {oe_sync_q[0], output_enable_n_i};
      zz_sync_q <= {zz_sync_q[0], snooze_request_i};
    end
  end
  logic snooze;
  logic oe_n;
  assign snooze = zz_sync_q[1];
  assign oe_n = oe_sync_q[1];
  assign snoozing_o = snooze;

  // ==========================================================
  // strobe decode; enables only matter on an address strobe edge, which loads or powers down
  logic sel_ok;
  logic p_load;
  logic p_down;
  logic c_load;
  logic c_down;
  logic load;
  logic [LANES-1:0] lane_we;
  logic any_we;
  assign sel_ok = !sel_i.primary_select_n && !sel_i.second_select_n
                  && sel_i.second_select_high;
  // processor strobe counts only with primary enable low
  assign p_load = !snooze && !strb_i.processor_addr_strobe_n
                  && !sel_i.primary_select_n && sel_ok;
  assign p_down = !snooze && !strb_i.processor_addr_strobe_n
                  && !sel_i.primary_select_n && !sel_ok;
  // processor strobe wins; the controller one only acts without it
  assign c_load = !snooze && strb_i.processor_addr_strobe_n
                  && !strb_i.controller_addr_strobe_n
                  && !sel_i.primary_select_n && sel_ok;
  assign c_down = !snooze && strb_i.processor_addr_strobe_n
                  && !strb_i.controller_addr_strobe_n
                  && (sel_i.primary_select_n || !sel_ok);
  assign load = p_load || c_load;
  always_comb begin
    if (!wr_i.full_word_write_n) begin
      lane_we = '1;
    end else if (!wr_i.byte_write_permit_n) begin
      lane_we = ~wr_i.lane_write_n;
    end else begin
      lane_we = '0;
    end
  end
  assign any_we = |lane_we;

  // ==========================================================
  // burst state
  logic active_q;
  logic writing_q;
  logic first_q;
  logic [AW-1:0] base_q;
  logic [`SBSC_BURST_W-1:0] cnt_q;
  logic step;
  assign step = !snooze && active_q && !load && !p_down && !c_down
                && !strb_i.burst_step_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_q <= 1'b0;
      writing_q <= 1'b0;
      base_q <= '0;
      cnt_q <= '0;
      first_q <= 1'b0;
    end else if (!snooze) begin
      first_q <= p_load;
      if (load) begin
        active_q <= 1'b1;
        base_q <= addr_i;
        cnt_q <= '0;
        writing_q <= c_load && any_we;
      end else if (p_down || c_down) begin
        active_q <= 1'b0;
        writing_q <= 1'b0;
      end else if (step) begin
        cnt_q <= cnt_q + 2'h1;
        if (!strb_i.controller_addr_strobe_n || first_q) begin
          writing_q <= writing_q;
        end
      end
      // after a processor load, a write may follow in burst cycles
      if (!load && active_q && !p_down && !c_down && !first_q) begin
        writing_q <= any_we;
      end
    end
  end
  assign powered_down_o = !active_q;

  // burst address: linear adds, interleaved xors
  logic [`SBSC_BURST_W-1:0] low_bits;
  assign low_bits = burst_order_i ? (base_q[1:0] ^ cnt_q)
                    : (base_q[1:0] + cnt_q);
  logic [AW-1:0] cur_addr;
  assign cur_addr = {base_q[AW-1:2], low_bits};

  // ==========================================================
  // pipelined access: address registered, then array, then output
  logic [LANES-1:0] mem_we;
  logic mem_en;
  logic rd_valid_q;
  logic rd_pend_q;
  logic [LANES*LW-1:0] wdata;
  assign mem_en = active_q && !snooze;
  assign mem_we = (mem_en && writing_q) ? lane_we : '0;
  // parity bit in each lane only exists on parity versions
  always_comb begin
    wdata = data_i;
    if (!HAS_PARITY) begin
      for (int i = 0; i < LANES; i++) begin
        wdata[i*LW+LW-1] = 1'b0;
      end
    end
  end
  logic [LANES*LW-1:0] rdata;
  sbsc_mem #(.AW(AW), .LANES(LANES), .LW(LW)) u_mem (
    .clk_i(clk_i),
    .en_i(mem_en),
    .we_i(mem_we),
    .addr_i(cur_addr),
    .wdata_i(wdata),
    .rdata_o(rdata)
  );
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend_q <= 1'b0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_pend_q <= mem_en && !writing_q;
      rd_valid_q <= rd_pend_q && !snooze;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= '0;
    end else if (rd_pend_q) begin
      data_o <= rdata;
    end
  end
  // drivers follow the output enable pin, gated by valid read data (rd_valid_q) and by snooze
  assign data_oe_n_o = (!oe_n && rd_valid_q && !snooze) ? '0 : '1;

  // ==========================================================
  // checks
  a_sel_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (load |-> sel_ok && !sel_i.primary_select_n)) else $error("load while not selected");
  a_p_ignore: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (sel_i.primary_select_n |-> !p_load && !p_down)) else $error("processor strobe used");
  a_p_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (p_load |=> active_q && !writing_q && cnt_q == 2'h0)) else $error("processor load not read");
  a_c_down: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (c_down |=> !active_q)) else $error("controller strobe no powerdown");
  a_p_down: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (p_down |=> !active_q)) else $error("processor strobe no powerdown");
  a_step_cnt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (step |=> cnt_q == $past(cnt_q) + 2'h1)) else $error("burst not stepped");
  a_hold_cnt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (active_q && !load && strb_i.burst_step_n |=> cnt_q == $past(cnt_q)))
    else $error("burst moved on wait");
  a_oe_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (oe_n |-> data_oe_n_o == '1)) else $error("drove with oe high");
  a_snooze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (snooze |=> $stable(base_q) && $stable(cnt_q))) else $error("state moved in snooze");
  a_gw_all: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!wr_i.full_word_write_n |-> lane_we == '1)) else $error("full write missed lane");
  a_c_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (c_load && any_we |=> active_q && writing_q)) else $error("controller write not taken");
endmodule : sbsc_top
`default_nettype wire

// file: core/sbsc_defs.svh
// What this block does
// - chip enables are sampled only on address strobe edges, which load a new address or power down.
// - selected only when primary low, second low-active low, second high-active high.
// - data drivers enabled only while output enable is low, sampled through a two-flop synchroniser.
// - burst counter steps on each edge where burst step is low.
// - burst step high holds the burst address, giving a wait state.
// - processor strobe while selected aborts burst, loads address and reads.
// - processor strobe is ignored whenever primary enable is high; this block still lets a low processor strobe mask the controller strobe.
// - processor strobe with primary low but secondary deasserted powers down.
// - controller strobe while selected loads address, reads or writes.
// - controller strobe with primary enable high powers down; this block does so only while the processor strobe is high.
// - burst order linear when order select low, interleaved when high.
// - snooze high forces standby, keeps contents, ignores all other inputs.
// - data grouped in byte lanes; write data captured on rising edge.
// - one parity bit per byte lane on 18- and 36-bit versions.
// - lane write enable low writes; it governs its lane's data and parity.
// - full word write low writes all lanes regardless of other enables.
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH
`define SBSC_ADDR_W 17
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_BURST_W 2
`endif

// file: core/sbsc_pkg.sv
`default_nettype none
`include "sbsc_defs.svh"
package sbsc_pkg;
  typedef struct packed {
    logic primary_select_n;
    logic second_select_n;
    logic second_select_high;
  } sbsc_sel_t;
  typedef struct packed {
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_step_n;
  } sbsc_strb_t;
  typedef struct packed {
    logic full_word_write_n;
    logic byte_write_permit_n;
    logic [`SBSC_LANES-1:0] lane_write_n;
  } sbsc_wr_t;
  typedef enum logic [1:0] {SBSC_IDLE, SBSC_READ, SBSC_WRITE} sbsc_op_t;
endpackage : sbsc_pkg
`default_nettype wire

// file: core/sbsc_mem.sv
`timescale 1ns/1ns
`default_nettype none
module sbsc_mem #(
  parameter int AW = 17,
  parameter int LANES = 4,
  parameter int LW = 9
) (
  // clock
  input wire logic clk_i,
  // access
  input wire logic en_i,
  input wire logic [LANES-1:0] we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [LANES*LW-1:0] wdata_i,
  output logic [LANES*LW-1:0] rdata_o
);
  logic [LANES*LW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_i) begin
    if (en_i) begin
      rdata_o <= mem[addr_i];
    end
  end
  // one writer process for the whole array; lanes only pick their slice
  always_ff @(posedge clk_i) begin
    for (int g = 0; g < LANES; g++) begin
      if (en_i && we_i[g]) begin
        mem[addr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
      end
    end
  end
endmodule : sbsc_mem
`default_nettype wire

// file: sim/sbsc_master.sv
`timescale 1ns/1ns
`default_nettype none
module sbsc_master import sbsc_pkg::*; (
  // clock
  input wire logic clk_i,
  // pins toward the memory
  output var sbsc_pkg::sbsc_sel_t sel_o,
  output var sbsc_pkg::sbsc_strb_t strb_o,
  output var sbsc_pkg::sbsc_wr_t wr_o,
  output var logic [16:0] addr_o,
  output var logic [35:0] data_o
);
  // ==========
  // bus cycles
  initial begin
    sel_o = 3'h1;
    strb_o = 3'h7;
    wr_o = 6'h3F;
    addr_o = 17'h00000;
    data_o = 36'h000000000;
  end
  task automatic put(input logic [2:0] s, input logic [2:0] t, input logic [5:0] w,
    input logic [16:0] a, input logic [35:0] d);
    @(posedge clk_i);
    sel_o <= s;
    strb_o <= t;
    wr_o <= w;
    addr_o <= a;
    data_o <= d;
  endtask : put
  // released lines flip each cycle so a stale value never looks valid
  task automatic idle(input int n);
    repeat (n) put(3'h1, 3'h7, 6'h3F, ~addr_o, ~data_o);
  endtask : idle
endmodule : sbsc_master
`default_nettype wire

// file: sim/sbsc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sbsc_top_tb_top;
  import sbsc_pkg::*;
  typedef struct {logic [16:0] a; logic [5:0] w; logic [35:0] d; logic [35:0] e;} sbsc_row_t;
  // ==========
  // stimulus and checks
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic burst_order_i = 1'b0;
  logic output_enable_n_i = 1'b0;
  logic snooze_request_i = 1'b0;
  sbsc_sel_t sel;
  sbsc_strb_t strb;
  sbsc_wr_t wr;
  logic [16:0] addr;
  logic [35:0] din, dout, oe_n;
  logic snoozing, pdown;
  int err_total = 0;
  int n_compared = 0;
  logic [35:0] mem_e [4];
  sbsc_row_t rows [7] = '{'{17'h4, 6'h0F, 36'h123456789, 36'h123456789},
    '{17'h5, 6'h0F, 36'hABCDEF012, 36'hABCDEF012}, '{17'h6, 6'h0F, 36'h0F0F0F0F0, 36'h0F0F0F0F0},
    '{17'h7, 6'h0F, 36'hFEDCBA987, 36'hFEDCBA987}, '{17'h5, 6'h2A, 36'h000000000, 36'hAB802F000},
    '{17'h7, 6'h30, 36'h000000000, 36'hFEDCBA987}, '{17'h6, 6'h05, 36'h555555555, 36'h555555555}};
  always #2 clk_i = ~clk_i;
  sbsc_master sbsc_master_inst (.clk_i(clk_i), .sel_o(sel), .strb_o(strb), .wr_o(wr), .addr_o(addr),
    .data_o(din));
  sbsc_top sbsc_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .sel_i(sel), .strb_i(strb),
    .wr_i(wr), .burst_order_i(burst_order_i), .output_enable_n_i(output_enable_n_i),
    .snooze_request_i(snooze_request_i), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n),
    .snoozing_o(snoozing), .powered_down_o(pdown));
  task automatic check(input string n, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : check
  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic wr_word(input logic [16:0] a, input logic [5:0] w, input logic [35:0] d);
    sbsc_master_inst.put(3'h1, 3'h5, w, a, d);
    sbsc_master_inst.put(3'h1, 3'h7, w, a, d);
    sbsc_master_inst.idle(1);
  endtask : wr_word
  task automatic rd(input logic [16:0] a, input logic [35:0] e);
    sbsc_master_inst.put(3'h1, 3'h3, 6'h3F, a, ~e);
    sbsc_master_inst.idle(3);
    #1 check("read data", e, dout);
    check("drivers", 36'h0, oe_n);
  endtask : rd
  // one step per pulse, waits between, so the latency cannot hide the order
  task automatic burst(input logic [1:0] b);
    rd({15'h1, b}, mem_e[b]);
    for (int k = 1; k <= 4; k++) begin
      sbsc_master_inst.put(3'h1, 3'h6, 6'h3F, 17'h1FFFF, 36'h0);
      sbsc_master_inst.idle(3);
      #1 check("burst", mem_e[burst_order_i ? b ^ k[1:0] : b + k[1:0]], dout);
    end
  endtask : burst
  initial begin
    repeat (5) @(posedge clk_i);
    #1 check("reset", 36'h1, {dout[33:0], snoozing, pdown} | {oe_n !== '1, 35'h0});
    arst_n_i <= 1'b1;
    foreach (rows[i]) begin
      wr_word(rows[i].a, rows[i].w, rows[i].d);
      rd(rows[i].a, rows[i].e);
      mem_e[rows[i].a[1:0]] = rows[i].e;
    end
    check("active", 36'h0, {35'h0, pdown});
    burst(2'h1);
    output_enable_n_i <= 1'b1;
    sbsc_master_inst.idle(3);
    #1 check("drivers off", '1, oe_n);
    output_enable_n_i <= 1'b0;
    sbsc_master_inst.put(3'h5, 3'h3, 6'h3F, 17'h4, 36'h0);
    sbsc_master_inst.idle(3);
    #1 check("ignored strobe", mem_e[1], dout);
    check("still active", 36'h0, {35'h0, pdown});
    sbsc_master_inst.put(3'h0, 3'h3, 6'h3F, 17'h4, 36'h0);
    sbsc_master_inst.idle(2);
    #1 check("power down", 36'h1, {35'h0, pdown});
    rd(17'h4, mem_e[0]);
    // low-active second enable deasserted while a burst is open
    sbsc_master_inst.put(3'h3, 3'h3, 6'h3F, 17'h4, 36'h0);
    sbsc_master_inst.idle(2);
    #1 check("power down n", 36'h1, {35'h0, pdown});
    rd(17'h4, mem_e[0]);
    sbsc_master_inst.put(3'h5, 3'h5, 6'h3F, 17'h4, 36'h0);
    sbsc_master_inst.idle(2);
    #1 check("power down", 36'h1, {35'h0, pdown});
    snooze_request_i <= 1'b1;
    sbsc_master_inst.idle(3);
    #1 check("snoozing", 36'h1, {35'h0, snoozing});
    wr_word(17'h4, 6'h0F, 36'h0);
    snooze_request_i <= 1'b0;
    sbsc_master_inst.idle(3);
    rd(17'h4, mem_e[0]);
    arst_n_i <= 1'b0;
    burst_order_i <= 1'b1;
    sbsc_master_inst.idle(2);
    arst_n_i <= 1'b1;
    burst(2'h2);
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    err_total++;
    report_and_stop();
  end
endmodule : sbsc_top_tb_top
`default_nettype wire
